// ==== bench/sdru_mem_model.sv ====
// Memory and bus sequencer stand-in on the far side
module sdru_mem_model (
  input wire logic clk,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  output logic mem_rvalid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [int];
  int lag = 0;
  // One answer per read, after lag cycles; data scrambled outside the answer
  initial begin
    mem_rvalid = 1'b0;
    mem_rdata = 8'h5A;
    forever begin
      @(posedge clk);
      if (mem_rd) begin
        repeat (lag) @(posedge clk);
        mem_rvalid <= 1'b1;
        mem_rdata <= mem[mem_addr];
        @(posedge clk);
        mem_rvalid <= 1'b0;
        mem_rdata <= ~mem_rdata;
        @(posedge clk);
      end
    end
  end
  always @(posedge clk) begin
    if (mem_wr) mem[mem_addr] = mem_wdata;
  end
endmodule

// ==== bench/sdru_top_properties.sv ====
// Port checker of the shift and digit rotate slice
module sdru_check (
  input wire logic clk,
  input wire logic rst,
  input wire logic op_valid,
  input wire logic op_ready,
  input wire logic [7:0] op_byte,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_rvalid,
  input wire logic [15:0] first_index_register,
  input wire logic [15:0] second_index_register,
  input wire logic [7:0] flags_reg,
  input wire logic [7:0] acc_reg,
  input wire logic [15:0] memory_pointer_pair_reg,
  input wire logic done,
  input wire logic [2:0] mcycles_reg,
  input wire logic [4:0] tstates_reg
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] hist_reg;
  logic [7:0] rd_reg;
  logic [7:0] ac_reg;
  logic fc_reg;
  // Last four bytes taken, so the form of the running op is known
  // Cleared in reset so the first short form does not see unknown prefixes
  always_ff @(posedge clk) begin
    if (rst) begin
      hist_reg <= 32'h00000000;
    end else if (op_valid && op_ready) begin
      hist_reg <= {hist_reg[23:0], op_byte};
    end
  end
  // Operand, accumulator and carry as they stood at the read answer
  always_ff @(posedge clk) begin
    if (mem_rvalid) begin
      rd_reg <= mem_rdata;
      ac_reg <= acc_reg;
      fc_reg <= flags_reg[0];
    end
  end
  wire [7:0] op = hist_reg[7:0];
  wire idx = hist_reg[23:16] == 8'hCB && (hist_reg[31:24] == 8'hDD || hist_reg[31:24] == 8'hFD);
  wire [15:0] base = hist_reg[31:24] == 8'hDD ? first_index_register : second_index_register;
  wire [15:0] ea = base + {{8{hist_reg[15]}}, hist_reg[15:8]};
  wire shm = mem_wr && op != 8'h6F;
  wire [7:0] wd = op == 8'h26 ? {rd_reg[6:0], 1'b0} : op == 8'h2E ? {rd_reg[7], rd_reg[7:1]} :
    op == 8'h3E ? {1'b0, rd_reg[7:1]} : {rd_reg[3:0], ac_reg[3:0]};
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_rd_wr; mem_rvalid |-> ##2 (mem_wr && done); endproperty
  a_rd_wr: assert property (p_rd_wr) else $error("write not two cycles after read answer");
  property p_wdata; mem_wr |-> mem_wdata == wd; endproperty
  a_wdata: assert property (p_wdata) else $error("written byte wrong");
  property p_zero; shm |=> flags_reg[6] == ($past(mem_wdata) == 8'h00) && !flags_reg[4] && !flags_reg[1]; endproperty
  a_zero: assert property (p_zero) else $error("zero, half or subtract flag wrong");
  property p_par; shm |=> flags_reg[2] == ~^$past(mem_wdata); endproperty
  a_par: assert property (p_par) else $error("parity flag wrong");
  property p_sign; shm |=> flags_reg[7] == ($past(op) != 8'h3E && $past(mem_wdata[7])); endproperty
  a_sign: assert property (p_sign) else $error("sign flag wrong");
  property p_carry; shm |=> flags_reg[0] == ($past(op) == 8'h26 ? rd_reg[7] : rd_reg[0]); endproperty
  a_carry: assert property (p_carry) else $error("carry flag wrong");
  property p_digit;
    mem_wr && op == 8'h6F |=> acc_reg == {ac_reg[7:4], rd_reg[7:4]} && flags_reg[0] == fc_reg &&
      flags_reg[7] == acc_reg[7] && flags_reg[6] == (acc_reg == 8'h00) && flags_reg[2] == ~^acc_reg &&
      mcycles_reg == 3'h5 && tstates_reg == 5'h12;
  endproperty
  a_digit: assert property (p_digit) else $error("digit rotate result wrong");
  property p_addr; mem_rd |-> mem_addr == (idx ? ea : memory_pointer_pair_reg); endproperty
  a_addr: assert property (p_addr) else $error("memory address wrong");
  property p_cyc_mem; shm |=> tstates_reg == ($past(idx) ? 5'h17 : 5'h0F) && mcycles_reg == ($past(idx) ? 3'h6 : 3'h4);
  endproperty
  a_cyc_mem: assert property (p_cyc_mem) else $error("memory form cycle figures wrong");
  property p_cyc_reg; done && !mem_wr |=> mcycles_reg == 3'h2 && tstates_reg == 5'h08; endproperty
  a_cyc_reg: assert property (p_cyc_reg) else $error("register form cycle figures wrong");
  c_idx: cover property (shm && idx);
  c_dig: cover property (mem_wr && op == 8'h6F);
  c_reg: cover property (done && !mem_wr);
endmodule
bind sdru_top sdru_check u_chk (.*);

// ==== bench/shift_and_digit_rotate_unit_test.sv ====
// Self-checking bench of the shift and digit rotate slice
module shift_and_digit_rotate_unit_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic op_valid = 1'b0;
  logic [7:0] op_byte = 8'h00;
  logic [15:0] first_index_register = 16'h0000;
  logic [15:0] second_index_register = 16'h0000;
  logic [2:0] reg_sel = 3'h0;
  logic op_ready, mem_rd, mem_wr, mem_rvalid, done, illegal;
  logic [15:0] mem_addr, memory_pointer_pair_reg;
  logic [7:0] mem_wdata, mem_rdata, flags_reg, acc_reg, reg_dump;
  logic [2:0] mcycles_reg;
  logic [4:0] tstates_reg;
  logic [7:0] gpr [8] = '{default: 8'h00};
  logic [7:0] f = 8'h00;
  logic [7:0] pfx [4] = '{8'h00, 8'hDD, 8'hFD, 8'hED};
  logic [2:0] grp [3] = '{3'h4, 3'h5, 3'h7};
  logic [31:0] seed = 32'h00014E10;
  logic [31:0] expq [$];
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  sdru_top u_dut (.*);
  sdru_mem_model u_mem (.*);
  always #25 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("Comparisons %0d, errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Valid stays up between bytes so no edge sees it written twice
  task automatic send(input logic [7:0] b);
    op_valid <= 1'b1;
    op_byte <= b;
    @(posedge clk);
    while (op_ready !== 1'b1) @(posedge clk);
  endtask
  // One instruction: note the expected outcome, then feed its bytes
  task automatic op(input logic [7:0] pf, input logic [7:0] d, input logic [7:0] ob, input logic [7:0] m);
    logic mem;
    logic c;
    logic [7:0] v, r, a;
    logic [15:0] ad;
    if (pf != 8'h00) ob[2:0] = 3'h6;
    mem = ob[2:0] == 3'h6;
    v = mem ? m : gpr[ob[2:0]];
    ad = {gpr[4], gpr[5]};
    if (pf == 8'hDD) ad = first_index_register + {{8{d[7]}}, d};
    if (pf == 8'hFD) ad = second_index_register + {{8{d[7]}}, d};
    u_mem.mem[ad] = m;
    a = gpr[7];
    if (pf == 8'hED) begin
      r = {v[3:0], a[3:0]};
      gpr[7] = {a[7:4], v[7:4]};
      a = gpr[7];
      f = {a[7], a == 8'h00, f[5], 1'b0, f[3], ~^a, 1'b0, f[0]};
      expq.push_back({8'hB2, f, r, a});
    end else begin
      c = ob[5:3] == 3'h4 ? v[7] : v[0];
      r = ob[5:3] == 3'h4 ? {v[6:0], 1'b0} : {ob[4] ? 1'b0 : v[7], v[7:1]};
      f = {r[7], r == 8'h00, f[5], 1'b0, f[3], ~^r, 1'b0, c};
      if (!mem) gpr[ob[2:0]] = r;
      // Cycle figures packed as mcycles then tstates: 6/23, 4/15, 2/8
      expq.push_back({pf != 8'h00 ? 8'hD7 : mem ? 8'h8F : 8'h48, f, r, gpr[7]});
    end
    reg_sel <= ob[2:0];
    if (pf != 8'h00) send(pf);
    if (pf != 8'hED) send(8'hCB);
    if (pf == 8'hDD || pf == 8'hFD) send(d);
    send(pf == 8'hED ? 8'h6F : ob);
    op_valid <= 1'b0;
    for (int k = 0; k < 40 && done !== 1'b1; k++) @(posedge clk);
    @(posedge clk);
  endtask
  // Refused sequence: its last byte raises illegal for one cycle and never done
  task automatic refuse(input logic [31:0] bytes, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      send(bytes[8*i +: 8]);
    end
    op_valid <= 1'b0;
    @(posedge clk);
    check({illegal, done}, 32'h2);
  endtask
  // Result watcher: each done takes the oldest note off the queue
  initial begin
    logic w;
    logic [7:0] d;
    forever begin
      @(posedge clk iff done === 1'b1);
      w = mem_wr;
      d = mem_wdata;
      @(posedge clk);
      check({mcycles_reg, tstates_reg, flags_reg, w ? d : reg_dump, acc_reg}, expq.size() ? expq.pop_front() : 'x);
    end
  end
  // Hang guard, far above the roughly 900 cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    check({mcycles_reg, tstates_reg, flags_reg, acc_reg, done, mem_rd, mem_wr}, 32'h0);
    rst <= 1'b0;
    for (int i = 0; i < 90; i++) begin
      seed = xs(seed);
      first_index_register <= seed[15:0];
      second_index_register <= seed[31:16];
      u_mem.lag = seed[5:4];
      @(posedge clk);
      seed = xs(seed);
      op(pfx[seed[1:0]], seed[31:24], {2'b00, grp[seed[3:2] % 3], seed[10:8]}, seed[23:16]);
    end
    // Stray byte, prefix without CB, bad rotate byte, indexed form naming a register
    refuse(32'h00000000, 1);
    refuse(32'h0000DD00, 2);
    refuse(32'h0000ED00, 2);
    refuse(32'hDDCB0521, 4);
    repeat (3) @(posedge clk);
    check(expq.size(), 32'h0);
    tally_and_finish();
  end
endmodule

// ==== core/sdru_alu.sv ====
// Combinational shifter, digit rotator and flag generator
`include "sdru_cfg.svh"
module sdru_alu (
  sdru_alu_if.alu a
);
  logic [7:0] res;
  logic [7:0] acc_n;
  logic cy;
  logic [7:0] fl;
  logic [7:0] tst;

  // Result and carry per operation
  always_comb begin
    res = a.operand;
    acc_n = a.acc;
    cy = a.flags_in[`SDRU_FLAG_C];
    if (a.digit) begin
      res = {a.operand[3:0], a.acc[3:0]};
      acc_n = {a.acc[7:4], a.operand[7:4]};
    end else begin
      unique case (a.kind)
        sdru_pkg::SDRU_SHL_ARITH: begin
          res = {a.operand[6:0], 1'b0};
          cy = a.operand[7];
        end
        sdru_pkg::SDRU_SHR_ARITH: begin
          res = {a.operand[7], a.operand[7:1]};
          cy = a.operand[0];
        end
        sdru_pkg::SDRU_SHR_LOGIC: begin
          res = {1'b0, a.operand[7:1]};
          cy = a.operand[0];
        end
        default: begin
          res = a.operand;
          cy = a.flags_in[`SDRU_FLAG_C];
        end
      endcase
    end
  end

  // Flags come from the accumulator after a digit rotate, else from the shifted byte
  always_comb begin
    tst = a.digit ? acc_n : res;
    fl = a.flags_in;
    fl[`SDRU_FLAG_S] = tst[7];
    fl[`SDRU_FLAG_Z] = (tst == 8'h00);
    fl[`SDRU_FLAG_PV] = ~^tst;
    fl[`SDRU_FLAG_H] = 1'b0;
    fl[`SDRU_FLAG_N] = 1'b0;
    fl[`SDRU_FLAG_C] = cy;
  end

  assign a.result = res;
  assign a.acc_out = acc_n;
  assign a.flags = fl;
endmodule

// ==== core/sdru_alu_if.sv ====
// Interface between the decoder and the shifter
interface sdru_alu_if;
  logic [7:0] operand;
  logic [7:0] acc;
  sdru_pkg::sdru_shift_e kind;
  logic digit;
  logic [7:0] result;
  logic [7:0] acc_out;
  logic [7:0] flags;
  logic [7:0] flags_in;
  modport ctrl (output operand, output acc, output kind, output digit, output flags_in,
                input result, input acc_out, input flags);
  modport alu (input operand, input acc, input kind, input digit, input flags_in,
               output result, output acc_out, output flags);
endinterface

// ==== core/sdru_cfg.svh ====
// Constants of the shift and digit rotate unit
`ifndef SDRU_CFG_SVH
`define SDRU_CFG_SVH
`define SDRU_PFX_BIT 8'hCB
`define SDRU_PFX_IDX1 8'hDD
`define SDRU_PFX_IDX2 8'hFD
`define SDRU_PFX_EXT 8'hED
`define SDRU_OP_DIGIT 8'h6F
`define SDRU_GRP_SLA 5'h04
`define SDRU_GRP_SRA 5'h05
`define SDRU_GRP_SRL 5'h07
`define SDRU_REG_MEM 3'h6
`define SDRU_REG_A 3'h7
`define SDRU_FLAG_C 0
`define SDRU_FLAG_N 1
`define SDRU_FLAG_PV 2
`define SDRU_FLAG_H 4
`define SDRU_FLAG_Z 6
`define SDRU_FLAG_S 7
`define SDRU_T_REG 5'h08
`define SDRU_T_PTR 5'h0F
`define SDRU_T_IDX 5'h17
`define SDRU_T_DIG 5'h12
`define SDRU_M_REG 3'h2
`define SDRU_M_PTR 3'h4
`define SDRU_M_IDX 3'h6
`define SDRU_M_DIG 3'h5
`endif

// ==== core/sdru_pkg.sv ====
// Types of the shift and digit rotate unit
package sdru_pkg;
  typedef enum logic [1:0] {
    SDRU_SHL_ARITH,
    SDRU_SHR_ARITH,
    SDRU_SHR_LOGIC
  } sdru_shift_e;
endpackage

// ==== core/sdru_top.sv ====
// Shift and digit rotate execution slice with its own register copy
`include "sdru_cfg.svh"
// Overview of operation
// - Left shift, old bit 7 to carry
// - Arithmetic right keeps bit 7, bit 0 carries
// - Logical right clears bit 7 and sign
// - Sign follows result for arithmetic shifts
// - Zero from result; half-carry, subtract cleared
// - Parity flag set on even ones
// - Register field codes; 110 means memory
// - Prefix CB, top five bits choose shift
// - Indexed: prefix, CB, displacement, operation byte
// - Cycle counts 2/8, 4/15, 6/23
// - Digit rotate left moves nibbles three ways
// - Accumulator high nibble stays unchanged
// - Digit rotate reads, writes memory at pointer
// - Digit rotate flags from accumulator, carry kept
// - Digit rotate takes 5 cycles, 18 states
module sdru_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic op_valid,
  output logic op_ready,
  input wire logic [7:0] op_byte,
  output logic mem_rd,
  output logic mem_wr,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_rvalid,
  input wire logic [15:0] first_index_register,
  input wire logic [15:0] second_index_register,
  output logic [7:0] flags_reg,
  output logic [7:0] acc_reg,
  output logic [15:0] memory_pointer_pair_reg,
  output logic [7:0] reg_dump,
  input wire logic [2:0] reg_sel,
  output logic done,
  output logic illegal,
  output logic [2:0] mcycles_reg,
  output logic [4:0] tstates_reg
);
  typedef enum logic [2:0] {
    SDRU_IDLE, SDRU_PFX, SDRU_DISP, SDRU_OPC, SDRU_READ, SDRU_WRITE
  } sdru_state_e;

  sdru_state_e st_reg;
  logic [7:0] gpr_reg [0:7];
  logic [7:0] first_reg;
  logic is_idx_reg;
  logic use_second_reg;
  logic is_digit_reg;
  logic [7:0] disp_reg;
  logic [7:0] opb_reg;
  logic [7:0] mem_byte_reg;
  logic [15:0] addr_next;
  logic [4:0] grp;
  logic grp_ok;
  sdru_pkg::sdru_shift_e kind_sel;
  sdru_alu_if alu_bus ();

  sdru_alu u_alu (
    .a(alu_bus)
  );

  assign op_ready = (st_reg == SDRU_IDLE) || (st_reg == SDRU_PFX) || (st_reg == SDRU_DISP) ||
                    (st_reg == SDRU_OPC);
  assign grp = op_byte[7:3];
  assign grp_ok = (grp == `SDRU_GRP_SLA) || (grp == `SDRU_GRP_SRA) || (grp == `SDRU_GRP_SRL);

  // Decode the group field into a shift kind
  always_comb begin
    unique case (opb_reg[7:3])
      `SDRU_GRP_SRA: kind_sel = sdru_pkg::SDRU_SHR_ARITH;
      `SDRU_GRP_SRL: kind_sel = sdru_pkg::SDRU_SHR_LOGIC;
      default: kind_sel = sdru_pkg::SDRU_SHL_ARITH;
    endcase
  end

  // Indexed address wraps modulo 64K like the real address bus
  always_comb begin
    if (is_digit_reg || !is_idx_reg) begin
      addr_next = memory_pointer_pair_reg;
    end else if (use_second_reg) begin
      addr_next = second_index_register + {{8{disp_reg[7]}}, disp_reg};
    end else begin
      addr_next = first_index_register + {{8{disp_reg[7]}}, disp_reg};
    end
  end

  assign alu_bus.operand = (st_reg == SDRU_WRITE) ? mem_byte_reg : gpr_reg[opb_reg[2:0]];
  assign alu_bus.acc = gpr_reg[`SDRU_REG_A];
  assign alu_bus.kind = kind_sel;
  assign alu_bus.digit = is_digit_reg;
  assign alu_bus.flags_in = flags_reg;
  assign acc_reg = gpr_reg[`SDRU_REG_A];
  assign memory_pointer_pair_reg = {gpr_reg[4], gpr_reg[5]};
  assign reg_dump = gpr_reg[reg_sel];

  // Sequencer: prefix bytes, displacement, operation byte, then memory read and write
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= SDRU_IDLE;
      first_reg <= 8'h00;
      is_idx_reg <= 1'b0;
      use_second_reg <= 1'b0;
      is_digit_reg <= 1'b0;
      disp_reg <= 8'h00;
      opb_reg <= 8'h00;
      mem_byte_reg <= 8'h00;
      illegal <= 1'b0;
    end else begin
      illegal <= 1'b0;
      unique case (st_reg)
        SDRU_IDLE: if (op_valid) begin
          first_reg <= op_byte;
          is_idx_reg <= 1'b0;
          is_digit_reg <= 1'b0;
          if (op_byte == `SDRU_PFX_BIT || op_byte == `SDRU_PFX_EXT) begin
            st_reg <= SDRU_OPC;
            is_digit_reg <= (op_byte == `SDRU_PFX_EXT);
          end else if (op_byte == `SDRU_PFX_IDX1 || op_byte == `SDRU_PFX_IDX2) begin
            st_reg <= SDRU_PFX;
            is_idx_reg <= 1'b1;
            use_second_reg <= (op_byte == `SDRU_PFX_IDX2);
          end else begin
            illegal <= 1'b1;
          end
        end
        SDRU_PFX: if (op_valid) begin
          if (op_byte == `SDRU_PFX_BIT) begin
            st_reg <= SDRU_DISP;
          end else begin
            st_reg <= SDRU_IDLE;
            illegal <= 1'b1;
          end
        end
        SDRU_DISP: if (op_valid) begin
          disp_reg <= op_byte;
          st_reg <= SDRU_OPC;
        end
        SDRU_OPC: if (op_valid) begin
          opb_reg <= op_byte;
          if (is_digit_reg) begin
            if (op_byte == `SDRU_OP_DIGIT) st_reg <= SDRU_READ;
            else begin
              st_reg <= SDRU_IDLE;
              illegal <= 1'b1;
            end
          end else if (!grp_ok || (is_idx_reg && op_byte[2:0] != `SDRU_REG_MEM)) begin
            st_reg <= SDRU_IDLE;
            illegal <= 1'b1;
          end else if (op_byte[2:0] == `SDRU_REG_MEM) begin
            st_reg <= SDRU_READ;
          end else begin
            st_reg <= SDRU_IDLE;
          end
        end
        SDRU_READ: if (mem_rvalid) begin
          mem_byte_reg <= mem_rdata;
          st_reg <= SDRU_WRITE;
        end
        SDRU_WRITE: st_reg <= SDRU_IDLE;
        default: st_reg <= SDRU_IDLE;
      endcase
    end
  end

  // Memory strobes and write data come from flops
  always_ff @(posedge clk) begin
    if (rst) begin
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      mem_addr <= 16'h0000;
      mem_wdata <= 8'h00;
    end else begin
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      if (st_reg == SDRU_OPC && op_valid && (is_digit_reg ? op_byte == `SDRU_OP_DIGIT :
          (grp_ok && op_byte[2:0] == `SDRU_REG_MEM))) begin
        mem_rd <= 1'b1;
        mem_addr <= addr_next;
      end
      if (st_reg == SDRU_READ && !mem_rvalid) begin
        mem_rd <= 1'b1;
      end
      if (st_reg == SDRU_WRITE) begin
        mem_wr <= 1'b1;
        mem_wdata <= alu_bus.result;
      end
    end
  end

  // Register file and flags update at the end of each instruction
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        gpr_reg[i] <= 8'h00;
      end
      flags_reg <= 8'h00;
    end else if (st_reg == SDRU_WRITE) begin
      flags_reg <= alu_bus.flags;
      if (is_digit_reg) gpr_reg[`SDRU_REG_A] <= alu_bus.acc_out;
    end else if (st_reg == SDRU_IDLE && opb_reg[2:0] != `SDRU_REG_MEM && done && !is_digit_reg) begin
      gpr_reg[opb_reg[2:0]] <= alu_bus.result;
      flags_reg <= alu_bus.flags;
    end
  end

  // Completion pulse and cycle accounting of the finished instruction
  always_ff @(posedge clk) begin
    if (rst) begin
      done <= 1'b0;
      mcycles_reg <= 3'h0;
      tstates_reg <= 5'h00;
    end else begin
      done <= 1'b0;
      if (st_reg == SDRU_OPC && op_valid && !is_digit_reg && grp_ok && !is_idx_reg &&
          op_byte[2:0] != `SDRU_REG_MEM) begin
        done <= 1'b1;
        mcycles_reg <= `SDRU_M_REG;
        tstates_reg <= `SDRU_T_REG;
      end else if (st_reg == SDRU_WRITE) begin
        done <= 1'b1;
        mcycles_reg <= is_digit_reg ? `SDRU_M_DIG : (is_idx_reg ? `SDRU_M_IDX : `SDRU_M_PTR);
        tstates_reg <= is_digit_reg ? `SDRU_T_DIG : (is_idx_reg ? `SDRU_T_IDX : `SDRU_T_PTR);
      end
    end
  end
endmodule
